/* rtl/sdrc_pkg.sv */
package sdrc_pkg;
   // filter configuration word layout
   localparam int DEC_LSB          = 0;
   localparam int DEC_W            = 7;
   localparam int AVG_LSB          = 8;
   localparam int AVG_W            = 6;
   localparam logic [15:0] FILTER_RESET = 16'h0007;
   // modulator clock and base decimation
   localparam int MOD_CLK_HZ       = 512000;
   localparam int BASE_DECIM       = 64;
   localparam int AVG_OFFSET       = 3;
   localparam int CHOP_EXTRA       = 3;
   // settling counts, in results
   localparam int SETTLE_PLAIN     = 3;
   localparam int SETTLE_PLAIN_RA  = 4;
   localparam int SETTLE_AVG       = 1;
   localparam int SETTLE_AVG_RA    = 2;
   localparam int SETTLE_CHOP      = 2;
   // factor legality limits
   localparam int DEC_LIM_FULL     = 31;
   localparam int DEC_LIM_SMALL    = 63;
   localparam int AVG_LIM_SMALL    = 7;
   // timing
   localparam int SYS_CLK_HZ       = 10000000;
   localparam int SYS_PERIOD_NS    = 100;
   localparam int MOD_DIV          = SYS_CLK_HZ / MOD_CLK_HZ;
   localparam int FIRST_HOLD_US    = 60;
   localparam int FIRST_HOLD_CYC   = (FIRST_HOLD_US * 1000 + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
   localparam int RES_W            = 16;
   // multiplexer sources
   typedef enum logic [1:0] {
      SDRC_SRC_VOLT,
      SDRC_SRC_EXT_TEMP,
      SDRC_SRC_INT_TEMP
   } sdrc_src_e;
   typedef enum logic [1:0] {
      SDRC_GND_FLOAT,
      SDRC_GND_DIRECT,
      SDRC_GND_RES
   } sdrc_gnd_e;
endpackage

/* rtl/sdrc_top.sv */
`timescale 1ns/1ps
`default_nettype none
// Function
// [R01] ground-connect clear leaves the ground switch pin floating regardless of resistance bit
// [R02] ground-connect set: direct to ground if resistance bit 0, else via 20k path
// [R03] multiplexer selects exactly one of voltage, external or on-chip temperature
// [R04] attenuator buffers enable automatically whenever the voltage input is selected
// [R05] after a channel change with chop off, third result is first settled one; code: first or second with averaging, fourth with running average only
// [R06] no chop, no averaging: rate 512000/((dec+1)*64); settle 3, or 4 with running average
// [R07] averaging, no chop: rate further divided by 3+avg; settle 1, or 2 with running average
// [R08] chop on: divisor (dec+1)*64*(3+avg)+3, settle two, averaging options ignored
// [R09] first result held off an extra 60 us beyond settling
// [R10] software programs only legal decimation/averaging pairs
// [R11] each result is a 16-bit word; rate 4 Hz to 8 kHz
// [R12] decimation in bits 6:0, averaging in bits 13:8 of the filter word
// [R13] filter word 0x0007 gives 1 kHz with all options disabled
// [R14] channel, filter or chop change restarts settling and suppresses result valid
module sdrc_top
   import sdrc_pkg::*;
#(
   parameter int HOLD_CYC = FIRST_HOLD_CYC
) (
   input  wire logic             clk_sys_i,       // 10 MHz system clock
   input  wire logic             rstn_i,          // synchronous reset, active low
   input  wire logic [15:0]      filter_cfg_i,    // filter configuration word
   input  wire logic             chop_en_i,       // chop mode
   input  wire logic             avg_en_i,        // averaging enable
   input  wire logic             run_avg_en_i,    // running average enable
   input  wire logic             conv_en_i,       // converter enable
   input  wire logic [1:0]       src_sel_i,       // input source select
   input  wire logic             gnd_connect_i,   // ground-connect bit
   input  wire logic             gnd_res_sel_i,   // resistance-select bit
   input  wire logic [RES_W-1:0] mod_data_i,      // filtered word from analogue side
   input  wire logic             res_ready_i,     // consumer ready for result
   output logic                  mux_volt_o,      // select external voltage
   output logic                  mux_ext_temp_o,  // select external temperature circuit
   output logic                  mux_int_temp_o,  // select on-chip sensor
   output logic                  atten_buf_en_o,  // attenuator buffer enable
   output logic                  gnd_direct_o,    // ground switch pin direct to ground
   output logic                  gnd_res_o,       // ground switch pin via 20k path
   output logic                  cfg_legal_o,     // factor pair legal
   output logic                  settled_o,       // settling complete
   output logic                  res_valid_o,     // result word valid
   output logic [RES_W-1:0]      res_data_o       // result word
);
   // hold counter is 16 bits wide and the tick divider 8 bits wide
   if (HOLD_CYC < 1 || HOLD_CYC > 65535 || MOD_DIV < 2 || MOD_DIV > 256) begin : g_param_chk
      $error("HOLD_CYC must lie in 1 to 65535 and MOD_DIV in 2 to 256");
   end

   logic [DEC_W-1:0] dec_f;
   logic [AVG_W-1:0] avg_f;
   logic [31:0]      divisor;
   logic [2:0]       settle_n;
   assign dec_f = filter_cfg_i[DEC_LSB +: DEC_W];   // [R12]
   assign avg_f = filter_cfg_i[AVG_LSB +: AVG_W];   // [R12]

   // output word period in modulator ticks
   always_comb begin
      divisor = 32'((32'(dec_f) + 32'd1) * 32'(BASE_DECIM));   // [R06] [R13]
      if (chop_en_i) begin
         divisor  = 32'(divisor * (32'(avg_f) + 32'(AVG_OFFSET)) + 32'(CHOP_EXTRA));   // [R08]
         settle_n = 3'(SETTLE_CHOP);   // [R08]
      end else if (avg_en_i) begin
         divisor  = 32'(divisor * (32'(avg_f) + 32'(AVG_OFFSET)));   // [R07]
         settle_n = run_avg_en_i ? 3'(SETTLE_AVG_RA) : 3'(SETTLE_AVG);   // [R07]
      end else begin
         settle_n = run_avg_en_i ? 3'(SETTLE_PLAIN_RA) : 3'(SETTLE_PLAIN);   // [R06] [R05]
      end
   end

   // checker for software's factor choice
   always_comb begin
      if (dec_f <= DEC_W'(DEC_LIM_FULL))
         cfg_legal_o = 1'b1;   // [R10]
      else if (dec_f <= DEC_W'(DEC_LIM_SMALL))
         cfg_legal_o = (avg_f <= AVG_W'(AVG_LIM_SMALL));   // [R10]
      else
         cfg_legal_o = (avg_f == '0);   // [R10]
   end

   // multiplexer and ground switch
   sdrc_src_e src;
   sdrc_gnd_e gnd;
   always_comb begin
      unique case (src_sel_i)
         2'h1:    src = SDRC_SRC_EXT_TEMP;
         2'h2:    src = SDRC_SRC_INT_TEMP;
         default: src = SDRC_SRC_VOLT;   // [R03]
      endcase
   end
   always_comb begin
      if (!gnd_connect_i)
         gnd = SDRC_GND_FLOAT;   // [R01]
      else if (gnd_res_sel_i)
         gnd = SDRC_GND_RES;     // [R02]
      else
         gnd = SDRC_GND_DIRECT;  // [R02]
   end
   assign mux_volt_o     = (src == SDRC_SRC_VOLT);       // [R03]
   assign mux_ext_temp_o = (src == SDRC_SRC_EXT_TEMP);   // [R03]
   assign mux_int_temp_o = (src == SDRC_SRC_INT_TEMP);   // [R03]
   assign atten_buf_en_o = mux_volt_o;                   // [R04]
   assign gnd_direct_o   = (gnd == SDRC_GND_DIRECT);   // [R02]
   assign gnd_res_o      = (gnd == SDRC_GND_RES);      // [R01] [R02]

   // change detector on channel, filter and chop
   logic [18:0] cfg_snap_ff;
   logic        cfg_chg;
   assign cfg_chg = (cfg_snap_ff != {src_sel_i, chop_en_i, filter_cfg_i});
   always_ff @(posedge clk_sys_i) begin
      if (!rstn_i)
         cfg_snap_ff <= {2'h0, 1'b0, FILTER_RESET};
      else
         cfg_snap_ff <= {src_sel_i, chop_en_i, filter_cfg_i};
   end

   // modulator tick enable
   logic [7:0] pre_ff;
   logic       mod_tick;
   assign mod_tick = (pre_ff == 8'(MOD_DIV - 1));
   always_ff @(posedge clk_sys_i) begin
      if (!rstn_i || mod_tick)
         pre_ff <= 8'h00;
      else
         pre_ff <= pre_ff + 8'h01;
   end

   // word period counter and extra first-result hold
   logic [31:0] per_ff;
   logic [15:0] hold_ff;
   logic [2:0]  settle_ff;
   logic        conv_tick;
   assign conv_tick = conv_en_i && (hold_ff == '0) && mod_tick
                      && (per_ff >= divisor - 32'd1);
   always_ff @(posedge clk_sys_i) begin
      if (!rstn_i || !conv_en_i || cfg_chg)
         per_ff <= '0;   // [R14]
      else if (hold_ff != '0)
         per_ff <= '0;
      else if (mod_tick)
         per_ff <= (per_ff >= divisor - 32'd1) ? '0 : per_ff + 32'd1;   // [R11]
   end
   always_ff @(posedge clk_sys_i) begin
      if (!rstn_i || !conv_en_i)
         hold_ff <= 16'(HOLD_CYC);   // [R09]
      else if (hold_ff != '0)
         hold_ff <= hold_ff - 16'h0001;   // [R09]
   end

   // settling count in results
   always_ff @(posedge clk_sys_i) begin
      if (!rstn_i || !conv_en_i || cfg_chg)
         settle_ff <= '0;   // [R14]
      else if (conv_tick && settle_ff < settle_n)
         settle_ff <= settle_ff + 3'h1;   // [R05]
   end
   assign settled_o = (settle_ff >= settle_n);

   // two-entry result buffer
   logic [RES_W-1:0] buf_ff [2];
   logic [1:0]       cnt_ff;
   logic             rd_ff;
   logic             wr_ok;
   logic             push;
   logic             pop;
   assign wr_ok = (cnt_ff != 2'h2);
   assign push  = conv_tick && wr_ok && (settle_ff + 3'h1 >= settle_n) && !cfg_chg; // [R05]
   assign pop   = res_valid_o && res_ready_i;
   always_ff @(posedge clk_sys_i) begin
      if (!rstn_i || cfg_chg) begin
         cnt_ff <= 2'h0;   // [R14]
         rd_ff  <= 1'b0;
      end else begin
         cnt_ff <= cnt_ff + 2'(push) - 2'(pop);
         if (pop)
            rd_ff <= ~rd_ff;
      end
   end
   always_ff @(posedge clk_sys_i) begin
      if (!rstn_i) begin
         buf_ff[0] <= '0;
         buf_ff[1] <= '0;
      end else if (push) begin
         buf_ff[rd_ff ^ cnt_ff[0]] <= mod_data_i;   // [R11]
      end
   end
   assign res_valid_o = (cnt_ff != 2'h0);
   assign res_data_o  = buf_ff[rd_ff];

   a_gnd_float: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
      !gnd_connect_i |-> !gnd_direct_o && !gnd_res_o)   // [R01]
      else $error("ground switch pin not floating");
   a_gnd_mode: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
      gnd_connect_i |-> (gnd_res_o == gnd_res_sel_i) && (gnd_direct_o != gnd_res_sel_i)) // [R02]
      else $error("ground switch mode wrong");
   a_mux_onehot: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
      $onehot({mux_volt_o, mux_ext_temp_o, mux_int_temp_o}))   // [R03]
      else $error("multiplexer not one-hot");
   a_atten_auto: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
      atten_buf_en_o == mux_volt_o)   // [R04]
      else $error("attenuator enable mismatch");
   a_chg_flush: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
      cfg_chg |=> !res_valid_o && !settled_o)   // [R14]
      else $error("result valid after config change");
   // words left from an earlier run may still stand, so watch new pushes only
   a_hold_first: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
      $rose(conv_en_i) |-> !push [*8])   // [R09]
      else $error("result before hold-off");
   a_legal_hi: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
      (dec_f > 7'd63 && avg_f != 6'd0) |-> !cfg_legal_o)   // [R10]
      else $error("illegal pair flagged legal");
   a_settle_need: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
      push |-> settle_ff + 3'h1 >= settle_n)   // [R05]
      else $error("unsettled result pushed");
   a_settle_plain: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
      (!chop_en_i && !avg_en_i && !run_avg_en_i) |-> settle_n == 3'd3)   // [R06]
      else $error("plain settle count wrong");
   a_chop_div: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
      (chop_en_i && filter_cfg_i == 16'h0007) |-> divisor == 32'd1539)   // [R08]
      else $error("chop divisor wrong");
endmodule
`default_nettype wire

/* tb/sdrc_mod_model.sv */
`timescale 1ns/1ps
`default_nettype none
// analogue side: holds the word while converting, scrambles it while idle
module sdrc_mod_model
   import sdrc_pkg::*;
(
   input  wire logic             clk_sys_i,  // system clock
   input  wire logic             en_i,       // converter running
   input  wire logic [RES_W-1:0] word_i,     // word to present
   output logic      [RES_W-1:0] mod_data_o  // word toward the filter
);
   always_ff @(posedge clk_sys_i) begin
      mod_data_o <= en_i ? word_i : ~mod_data_o;
   end
endmodule
`default_nettype wire

/* tb/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
   import sdrc_pkg::*;
   localparam int HOLD = 4;
   localparam logic [15:0] WORD = 16'hA5C3;
   logic clk_sys_i = 1'b0, rstn_i = 1'b0, chop_en_i = 1'b0, avg_en_i = 1'b0;
   logic run_avg_en_i = 1'b0, conv_en_i = 1'b0, gnd_connect_i = 1'b0;
   logic gnd_res_sel_i = 1'b0, res_ready_i = 1'b0;
   logic [15:0] filter_cfg_i = FILTER_RESET;
   logic [1:0]  src_sel_i = 2'h0;
   logic [15:0] mod_data_i, res_data_o;
   logic mux_volt_o, mux_ext_temp_o, mux_int_temp_o, atten_buf_en_o;
   logic gnd_direct_o, gnd_res_o, cfg_legal_o, settled_o, res_valid_o;
   int err_total = 0;
   int tests_run = 0;
   always #50 clk_sys_i = ~clk_sys_i;
   sdrc_mod_model sdrc_mod_model_inst (.clk_sys_i(clk_sys_i), .en_i(conv_en_i),
      .word_i(WORD), .mod_data_o(mod_data_i));
   sdrc_top #(.HOLD_CYC(HOLD)) sdrc_top_inst (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i),
      .filter_cfg_i(filter_cfg_i), .chop_en_i(chop_en_i), .avg_en_i(avg_en_i),
      .run_avg_en_i(run_avg_en_i), .conv_en_i(conv_en_i), .src_sel_i(src_sel_i),
      .gnd_connect_i(gnd_connect_i), .gnd_res_sel_i(gnd_res_sel_i),
      .mod_data_i(mod_data_i), .res_ready_i(res_ready_i), .mux_volt_o(mux_volt_o),
      .mux_ext_temp_o(mux_ext_temp_o), .mux_int_temp_o(mux_int_temp_o),
      .atten_buf_en_o(atten_buf_en_o), .gnd_direct_o(gnd_direct_o), .gnd_res_o(gnd_res_o),
      .cfg_legal_o(cfg_legal_o), .settled_o(settled_o), .res_valid_o(res_valid_o),
      .res_data_o(res_data_o));
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      tests_run++;
      if (got !== exp) begin
         err_total++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task automatic t_gnd();
      for (int i = 0; i < 4; i++) begin
         @(negedge clk_sys_i);
         {gnd_connect_i, gnd_res_sel_i} = 2'(i);
         #1;
         chk("gnd_pins", {14'h0, i == 2, i == 3}, {14'h0, gnd_direct_o, gnd_res_o});
      end
   endtask
   task automatic t_mux();
      for (int s = 0; s < 4; s++) begin
         @(negedge clk_sys_i);
         src_sel_i = 2'(s);
         #1;
         chk("mux", {12'h0, s == 0 || s == 3, s == 1, s == 2, s == 0 || s == 3},
             {12'h0, mux_volt_o, mux_ext_temp_o, mux_int_temp_o, atten_buf_en_o});
      end
      @(negedge clk_sys_i);
      src_sel_i = 2'h0;
   endtask
   task automatic t_legal();
      int dv[9] = '{0, 31, 32, 32, 63, 64, 64, 127, 7};
      int av[9] = '{63, 63, 7, 8, 8, 0, 1, 0, 0};
      int ok[9] = '{1, 1, 1, 0, 0, 1, 0, 1, 1};
      for (int i = 0; i < 9; i++) begin
         @(negedge clk_sys_i);
         filter_cfg_i = {2'h0, 6'(av[i]), 1'b0, 7'(dv[i])};
         #1;
         chk("cfg_legal", 16'(ok[i]), {15'h0, cfg_legal_o});
      end
   endtask
   task automatic wait_valid(input int exp);
      int n;
      n = 0;
      while (res_valid_o !== 1'b1 && n < 40000) begin
         @(negedge clk_sys_i);
         n++;
      end
      chk("result_time", 16'h1, {15'h0, n > exp - 40 && n < exp + 60});
      chk("settled", 16'h1, {15'h0, settled_o});
      chk("result_word", WORD, res_data_o);
   endtask
   task automatic t_rate(input logic [15:0] cfg, input logic [2:0] md, input int st, input int dv);
      @(negedge clk_sys_i);
      rstn_i = 1'b0;
      conv_en_i = 1'b0;
      res_ready_i = 1'b0;
      filter_cfg_i = cfg;
      {chop_en_i, avg_en_i, run_avg_en_i} = md;
      repeat (2) @(negedge clk_sys_i);
      rstn_i = 1'b1;
      @(negedge clk_sys_i);
      conv_en_i = 1'b1;
      wait_valid(HOLD + st * dv * MOD_DIV);
   endtask
   task automatic t_buffer();
      int n;
      n = 0;
      repeat (3 * 64 * MOD_DIV) @(negedge clk_sys_i);
      chk("valid_stands", 16'h1, {15'h0, res_valid_o});
      while (res_valid_o === 1'b1 && n < 5) begin
         chk("buffer_word", WORD, res_data_o);
         res_ready_i = 1'b1;
         @(negedge clk_sys_i);
         n++;
      end
      res_ready_i = 1'b0;
      chk("buffer_depth", 16'h2, 16'(n));
   endtask
   task automatic t_flush();
      int n;
      n = 0;
      while (res_valid_o !== 1'b1 && n < 1400) begin
         @(negedge clk_sys_i);
         n++;
      end
      src_sel_i = 2'h1;
      repeat (2) @(negedge clk_sys_i);
      chk("flush_valid", 16'h0, {15'h0, res_valid_o});
      chk("flush_settled", 16'h0, {15'h0, settled_o});
      wait_valid(3 * 64 * MOD_DIV - 2);
      src_sel_i = 2'h0;
   endtask
   initial begin
      repeat (6) @(negedge clk_sys_i);
      rstn_i = 1'b1;
      t_gnd();
      t_mux();
      t_legal();
      t_rate(16'h0000, 3'b000, 3, 64);
      t_buffer();
      t_flush();
      t_rate(16'h0000, 3'b001, 4, 64);
      t_rate(16'h0000, 3'b010, 1, 192);
      t_rate(16'h0000, 3'b011, 2, 192);
      t_rate(16'h0000, 3'b100, 2, 195);
      t_rate(FILTER_RESET, 3'b000, 3, 512);
      give_verdict();
   end
   initial begin
      #9000000;
      err_total++;
      give_verdict();
   end
endmodule
`default_nettype wire
